// >>> rtl/std_timer_defines.svh
// constants for the standard timer: widths, limits and timing counts
`ifndef STD_TIMER_DEFINES_SVH
`define STD_TIMER_DEFINES_SVH

// ------------------------------------------------------------
// widths
// ------------------------------------------------------------
`define TMR_CNT_W 10
`define TMR_LEN_W 11

// ------------------------------------------------------------
// reset values and limits
// ------------------------------------------------------------
`define TMR_CNT_RST 10'h000
`define TMR_CNT_MAX 10'h3FF
`define TMR_FULL_LEN 11'h400
`define TMR_STEP_SHIFT 7

// ------------------------------------------------------------
// timing in ref clock cycles
// ------------------------------------------------------------
// capture flag follows the latch by one cycle
`define TMR_CAP_FLAG_DLY 1

`endif

// >>> rtl/std_timer_pkg.sv
// types shared by the standard timer modules
package std_timer_pkg;

  // ------------------------------------------------------------
  // modes and pin actions
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TIMER = 2'b11
  } mode_type;

  typedef enum logic [1:0] {
    ACT_INACTIVE = 2'b00,
    ACT_ACTIVE = 2'b01,
    ACT_PWM = 2'b10,
    ACT_PULSE = 2'b11
  } pin_act_type;

  // capture edge codes share the pin action field
  typedef enum logic [1:0] {
    CAP_RISE = 2'b00,
    CAP_FALL = 2'b01,
    CAP_BOTH = 2'b10,
    CAP_OFF = 2'b11
  } cap_edge_type;

  // ------------------------------------------------------------
  // state records
  // ------------------------------------------------------------
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_state_type;

  typedef struct packed {
    logic run;
    logic [9:0] cnt;
    logic [9:0] a_val;
    logic cap_pend;
    logic a_flag;
    logic p_flag;
    logic irq;
    logic out;
  } timer_state_type;

endpackage

// >>> rtl/pin_sync.sv
// two-flop synchroniser with edge detection for one input pin
`timescale 1ns/100ps
module pin_sync
  import std_timer_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic rise_o,
  output logic fall_o
);

  sync_state_type st_reg;
  sync_state_type st_next;

  // edges are judged between the second and third stage only
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rise_o = st_reg.s2 & ~st_reg.s3;
  assign fall_o = ~st_reg.s2 & st_reg.s3;

endmodule

// >>> rtl/pwm_limits.sv
// period and duty lengths of the pwm waveform from the two compare values
`timescale 1ns/100ps
`include "std_timer_defines.svh"
module pwm_limits
  import std_timer_pkg::*;
(
  input wire logic [9:0] compare_a_value_i,
  input wire logic [9:0] compare_p_value_i,
  input wire logic period_duty_swap_i,
  output logic [10:0] period_len_o,
  output logic [10:0] duty_len_o
);

  logic [10:0] p_len;
  logic [10:0] a_len;

  // only the three low bits of compare p scale by 128; zero means full range
  always_comb begin
    if (compare_p_value_i[2:0] == 3'h0) begin
      p_len = `TMR_FULL_LEN;
    end else begin
      p_len = {1'b0, compare_p_value_i[2:0], 7'h00};
    end
    if (compare_a_value_i == `TMR_CNT_RST) begin
      a_len = `TMR_FULL_LEN;
    end else begin
      a_len = {1'b0, compare_a_value_i};
    end
    if (period_duty_swap_i) begin
      period_len_o = a_len;
      duty_len_o = p_len;
    end else begin
      period_len_o = p_len;
      duty_len_o = {1'b0, compare_a_value_i};
    end
  end

endmodule

// >>> rtl/std_timer.sv
// standard 10-bit timer: pwm output, single pulse output and input capture
//
// What this block does
// - swap low: period is compare p bits 2:0 times 128, or 1024 at zero; duty compare a.
// - swap high: period from compare a; duty compare p bits 2:0 times 128, or 1024.
// - duty at or above period keeps the output active for the whole period.
// - the comparator holding the period clears the counter and starts a period.
// - counting continues while the pin is forced inactive or active.
// - clear source select has no effect in pwm mode.
// - a counter run rising edge starts the counter and the pulse leading edge.
// - an ext clock pin rising edge sets counter run in single pulse mode.
// - the pulse trailing edge follows counter run going low.
// - compare a match clears counter run, ends the pulse and raises the interrupt.
// - single pulse counter returns to zero only on run rising; p ignored.
// - mode 01 is capture; pin action picks the edge; run rising starts count.
// - the selected capture edge copies the counter into compare a, with interrupt.
// - in capture the counter runs freely until counter run falls.
// - compare p match clears the counter and interrupts; zero gives full range.
// - pin action 11 in capture disables capture but the counter keeps running.
// - capture pulses shorter than two timer clocks may be lost.
// - latch within 1.5 timer clocks of the edge; flag follows the latch.
// - capture has no output; level, invert, clear select and swap unused.
// - initial level sets pwm active polarity; invert flips the waveform.
// - counter and both compare values are 10 bits, counter reset to zero.
`timescale 1ns/100ps
`include "std_timer_defines.svh"
module std_timer
  import std_timer_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic timer_tick_i,
  input wire logic [1:0] operating_mode_select_i,
  input wire logic [1:0] pin_action_select_i,
  input wire logic period_duty_swap_i,
  input wire logic clear_source_select_i,
  input wire logic output_initial_level_i,
  input wire logic output_invert_i,
  input wire logic counter_run_wr_i,
  input wire logic counter_run_wdata_i,
  input wire logic compare_a_wr_i,
  input wire logic [9:0] compare_a_wdata_i,
  input wire logic [9:0] compare_p_value_i,
  input wire logic compare_a_flag_clr_i,
  input wire logic compare_p_flag_clr_i,
  input wire logic ext_clock_pin_i,
  input wire logic capture_input_pin_i,
  output logic counter_run_o,
  output logic [9:0] counter_value_o,
  output logic [9:0] compare_a_value_o,
  output logic compare_a_flag_o,
  output logic compare_p_flag_o,
  output logic timer_irq_o,
  output logic timer_out_o
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic ext_rise;
  logic cap_rise;
  logic cap_fall;

  pin_sync u_ext_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(ext_clock_pin_i),
    .rise_o(ext_rise),
    .fall_o()
  );

  // the sync depth is the capture latency; short pulses can be missed
  pin_sync u_cap_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(capture_input_pin_i),
    .rise_o(cap_rise),
    .fall_o(cap_fall)
  );

  // ------------------------------------------------------------
  // state and decode
  // ------------------------------------------------------------
  timer_state_type st_reg;
  timer_state_type st_next;

  logic [10:0] period_len;
  logic [10:0] duty_len;

  pwm_limits u_limits (
    .compare_a_value_i(st_reg.a_val),
    .compare_p_value_i(compare_p_value_i),
    .period_duty_swap_i(period_duty_swap_i),
    .period_len_o(period_len),
    .duty_len_o(duty_len)
  );

  mode_type mode;
  pin_act_type act;
  logic is_pwm;
  logic is_pulse;
  logic is_cap;
  logic set_req;
  logic clr_req;
  logic start;
  logic [9:0] cnt_inc;
  logic [9:0] period_last;
  logic [9:0] cap_limit;
  logic cap_hit;
  logic full_duty;
  logic pwm_level;
  logic a_set;
  logic p_set;

  assign mode = mode_type'(operating_mode_select_i);
  assign act = pin_act_type'(pin_action_select_i);
  assign is_pwm = (mode == MODE_PWM);
  // clear source select is never read: no mode here uses it
  assign is_pulse = is_pwm && (act == ACT_PULSE);
  assign is_cap = (mode == MODE_CAPTURE);
  assign cnt_inc = st_reg.cnt + 10'h001;
  assign period_last = period_len[9:0] - 10'h001;
  // compare p of zero lets the counter run to its top value
  assign cap_limit = (compare_p_value_i == `TMR_CNT_RST) ? `TMR_CNT_MAX
                     : compare_p_value_i;
  assign set_req = (counter_run_wr_i && counter_run_wdata_i) || (is_pulse && ext_rise);
  assign clr_req = counter_run_wr_i && !counter_run_wdata_i;
  assign start = !st_reg.run && set_req;
  assign full_duty = (duty_len >= period_len);

  // capture edge select; code 11 disables capture but not counting
  always_comb begin
    cap_hit = 1'b0;
    if (is_cap && st_reg.run) begin
      case (cap_edge_type'(pin_action_select_i))
        CAP_RISE: cap_hit = cap_rise;
        CAP_FALL: cap_hit = cap_fall;
        CAP_BOTH: cap_hit = cap_rise | cap_fall;
        CAP_OFF: cap_hit = 1'b0;
        default: cap_hit = 1'b0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.irq = 1'b0;
    st_next.cap_pend = 1'b0;
    a_set = 1'b0;
    p_set = 1'b0;
    pwm_level = 1'b0;
    if (start) begin
      st_next.run = 1'b1;
      st_next.cnt = `TMR_CNT_RST;
    end else if (st_reg.run && clr_req) begin
      st_next.run = 1'b0;
    end else if (st_reg.run && timer_tick_i) begin
      if (is_pulse) begin
        st_next.cnt = cnt_inc;
        if (cnt_inc == st_reg.a_val) begin
          st_next.run = 1'b0;
          a_set = 1'b1;
        end
      end else if (is_pwm) begin
        // counting goes on whatever the pin action forces
        if (st_reg.cnt == period_last) begin
          st_next.cnt = `TMR_CNT_RST;
        end else begin
          st_next.cnt = cnt_inc;
        end
        if (st_reg.cnt == period_last) begin
          if (period_duty_swap_i) begin
            a_set = 1'b1;
          end else begin
            p_set = 1'b1;
          end
        end
        if ({1'b0, cnt_inc} == duty_len) begin
          if (period_duty_swap_i) begin
            p_set = 1'b1;
          end else begin
            a_set = 1'b1;
          end
        end
      end else begin
        if (st_reg.cnt == cap_limit) begin
          st_next.cnt = `TMR_CNT_RST;
          p_set = 1'b1;
        end else begin
          st_next.cnt = cnt_inc;
        end
      end
    end
    // capture beats a software write to compare a in the same cycle
    if (cap_hit) begin
      st_next.a_val = st_reg.cnt;
      st_next.cap_pend = 1'b1;
    end else if (compare_a_wr_i) begin
      st_next.a_val = compare_a_wdata_i;
    end
    if (st_reg.cap_pend) begin
      a_set = 1'b1;
    end
    // a set arriving with its clear wins
    st_next.a_flag = (st_reg.a_flag && !compare_a_flag_clr_i) || a_set;
    st_next.p_flag = (st_reg.p_flag && !compare_p_flag_clr_i) || p_set;
    st_next.irq = a_set || p_set;
    // output level, taken from the next counter so the pin lines up with it
    if (is_pwm) begin
      if (act == ACT_PULSE) begin
        pwm_level = st_next.run;
      end else if (act == ACT_ACTIVE) begin
        pwm_level = 1'b1;
      end else if (act == ACT_PWM) begin
        pwm_level = st_next.run && (full_duty || ({1'b0, st_next.cnt} < duty_len));
      end else begin
        pwm_level = 1'b0;
      end
      st_next.out = (pwm_level ~^ output_initial_level_i) ^ output_invert_i;
    end else begin
      st_next.out = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign counter_run_o = st_reg.run;
  assign counter_value_o = st_reg.cnt;
  assign compare_a_value_o = st_reg.a_val;
  assign compare_a_flag_o = st_reg.a_flag;
  assign compare_p_flag_o = st_reg.p_flag;
  assign timer_irq_o = st_reg.irq;
  assign timer_out_o = st_reg.out;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_start_zero;
    start |=> (counter_run_o && counter_value_o == 10'h000);
  endproperty
  a_start_zero: assert property (p_start_zero) else $error("start did not zero counter");

  property p_pulse_end;
    (is_pulse && st_reg.run && timer_tick_i && !clr_req && cnt_inc == st_reg.a_val)
      |=> (!counter_run_o && compare_a_flag_o && timer_irq_o);
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse did not end on a match");

  property p_ext_trigger;
    (is_pulse && ext_rise && !st_reg.run && !clr_req) |=> counter_run_o;
  endproperty
  a_ext_trigger: assert property (p_ext_trigger) else $error("ext edge failed to start");

  property p_cap_latch;
    cap_hit |=> (compare_a_value_o == $past(counter_value_o))
      ##1 (compare_a_flag_o && timer_irq_o);
  endproperty
  a_cap_latch: assert property (p_cap_latch) else $error("capture latch or flag wrong");

  property p_cap_off;
    (is_cap && act == ACT_PULSE && !compare_a_wr_i) |=> $stable(compare_a_value_o);
  endproperty
  a_cap_off: assert property (p_cap_off) else $error("capture while disabled");

  property p_cap_wrap;
    (is_cap && st_reg.run && timer_tick_i && !clr_req && !start && st_reg.cnt == cap_limit)
      |=> (counter_value_o == 10'h000 && compare_p_flag_o && timer_irq_o);
  endproperty
  a_cap_wrap: assert property (p_cap_wrap) else $error("capture limit not honoured");

  property p_pwm_wrap;
    (is_pwm && !is_pulse && st_reg.run && timer_tick_i && !clr_req && st_reg.cnt == period_last)
      |=> counter_value_o == 10'h000;
  endproperty
  a_pwm_wrap: assert property (p_pwm_wrap) else $error("pwm period did not wrap");

  property p_full_duty;
    (is_pwm && act == ACT_PWM && st_reg.run && !clr_req && full_duty)
      |=> timer_out_o == ($past(output_initial_level_i) ^ $past(output_invert_i));
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("full duty output not active");

  property p_forced_low;
    (is_pwm && act == ACT_INACTIVE)
      |=> timer_out_o == (!$past(output_initial_level_i) ^ $past(output_invert_i));
  endproperty
  a_forced_low: assert property (p_forced_low) else $error("forced inactive level wrong");

  property p_no_out_capture;
    is_cap |=> !timer_out_o;
  endproperty
  a_no_out_capture: assert property (p_no_out_capture) else $error("capture drove output");

  c_pulse: cover property (is_pulse && start ##[1:1000] !counter_run_o);
  c_capture: cover property (cap_hit ##2 compare_a_flag_o);
  c_pwm_wrap: cover property (is_pwm && act == ACT_PWM && counter_value_o == 10'h000
    && counter_run_o);
  c_cap_limit: cover property (is_cap && p_set);

endmodule

// >>> testbench/ext_pins_model.sv
// model of the pins outside the timer: trigger source and capture signal
`timescale 1ns/100ps
module ext_pins_model (
  input wire logic ref_clk_i,
  output logic ext_clock_pin_o,
  output logic capture_input_pin_o
);
  initial begin
    ext_clock_pin_o = 1'b0;
    capture_input_pin_o = 1'b0;
  end

  // ------------------------------------------------------------
  // pin activity
  // ------------------------------------------------------------
  // the trigger is held for several clocks so the synchroniser cannot miss it
  task automatic trigger;
    @(posedge ref_clk_i);
    ext_clock_pin_o <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    ext_clock_pin_o <= 1'b0;
  endtask

  // each level is kept at least three timer clocks before the next change
  task automatic set_cap(input logic v);
    @(posedge ref_clk_i);
    capture_input_pin_o <= v;
  endtask
endmodule

// >>> testbench/tb_top.sv
// self-checking bench for the standard timer
`timescale 1ns/100ps
module tb_top;
  import std_timer_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic tick = 1'b1;
  logic [1:0] mode = 2'b00;
  logic [1:0] act = 2'b00;
  logic swap = 1'b0, clr_sel = 1'b0, init_lvl = 1'b1, inv = 1'b0;
  logic run_wr = 1'b0, run_d = 1'b0, a_wr = 1'b0, a_clr = 1'b0, p_clr = 1'b0;
  logic [9:0] a_d = 10'h000;
  logic [9:0] p_val = 10'h000;
  logic ext_pin, cap_pin, run_o, a_flag, p_flag, irq, tout;
  logic [9:0] cnt, a_val;
  int err_total = 0, n_compared = 0, div = 1, tick_cnt = 0;

  always #2.5 ref_clk_i = ~ref_clk_i;

  // slower ticks let capture timing be judged in timer clocks
  always @(posedge ref_clk_i) begin
    tick_cnt <= (tick_cnt + 1) % div;
    tick <= (tick_cnt == 0);
  end

  std_timer dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .timer_tick_i(tick),
    .operating_mode_select_i(mode), .pin_action_select_i(act),
    .period_duty_swap_i(swap), .clear_source_select_i(clr_sel),
    .output_initial_level_i(init_lvl), .output_invert_i(inv),
    .counter_run_wr_i(run_wr), .counter_run_wdata_i(run_d), .compare_a_wr_i(a_wr),
    .compare_a_wdata_i(a_d), .compare_p_value_i(p_val), .compare_a_flag_clr_i(a_clr),
    .compare_p_flag_clr_i(p_clr), .ext_clock_pin_i(ext_pin), .capture_input_pin_i(cap_pin),
    .counter_run_o(run_o), .counter_value_o(cnt), .compare_a_value_o(a_val),
    .compare_a_flag_o(a_flag), .compare_p_flag_o(p_flag), .timer_irq_o(irq),
    .timer_out_o(tout));

  ext_pins_model pins (.ref_clk_i(ref_clk_i), .ext_clock_pin_o(ext_pin),
    .capture_input_pin_o(cap_pin));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic write_run(input logic v);
    @(posedge ref_clk_i);
    run_wr <= 1'b1;
    run_d <= v;
    @(posedge ref_clk_i);
    run_wr <= 1'b0;
  endtask

  task automatic write_a(input logic [9:0] v);
    @(posedge ref_clk_i);
    a_wr <= 1'b1;
    a_d <= v;
    @(posedge ref_clk_i);
    a_wr <= 1'b0;
  endtask

  task automatic clear_flags;
    @(posedge ref_clk_i);
    a_clr <= 1'b1;
    p_clr <= 1'b1;
    @(posedge ref_clk_i);
    a_clr <= 1'b0;
    p_clr <= 1'b0;
  endtask

  // any window of one full period holds the same number of active cycles
  task automatic measure(input int n, output logic [15:0] hi, output logic [15:0] top);
    hi = 16'h0000;
    top = 16'h0000;
    repeat (n) begin
      @(posedge ref_clk_i);
      hi += {15'h0000, tout};
      if (cnt > top[9:0]) top = {6'h00, cnt};
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_reset;
    check({6'h00, cnt}, 16'h0000);
    check({6'h00, a_val}, 16'h0000);
    check({12'h000, run_o, a_flag, p_flag, tout}, 16'h0000);
  endtask

  task automatic pwm_case(input logic sw, input logic [1:0] ac, input logic lv,
      input logic iv, input logic cs, input logic [9:0] p, input logic [9:0] a, input int n,
      input logic [15:0] exp_hi, input logic [15:0] exp_top);
    logic [15:0] hi, top;
    write_run(1'b0);
    @(posedge ref_clk_i);
    mode <= MODE_PWM;
    act <= ac;
    swap <= sw;
    init_lvl <= lv;
    inv <= iv;
    clr_sel <= cs;
    p_val <= p;
    write_a(a);
    write_run(1'b1);
    cyc(4);
    measure(n, hi, top);
    check(hi, exp_hi);
    check(top, exp_top);
  endtask

  task automatic test_pwm;
    pwm_case(0, 2'b10, 1, 0, 0, 10'h001, 10'h020, 128, 16'h0020, 16'h007F);
    pwm_case(0, 2'b10, 1, 0, 0, 10'h000, 10'h064, 1024, 16'h0064, 16'h03FF);
    pwm_case(1, 2'b10, 1, 1, 1, 10'h001, 10'h0C8, 200, 16'h0048, 16'h00C7);
    pwm_case(0, 2'b10, 1, 0, 0, 10'h001, 10'h12C, 128, 16'h0080, 16'h007F);
    pwm_case(0, 2'b00, 1, 0, 0, 10'h001, 10'h020, 128, 16'h0000, 16'h007F);
    pwm_case(0, 2'b01, 1, 0, 0, 10'h001, 10'h020, 128, 16'h0080, 16'h007F);
    pwm_case(0, 2'b10, 0, 0, 0, 10'h001, 10'h020, 128, 16'h0060, 16'h007F);
  endtask

  task automatic test_pulse;
    logic [15:0] hi, top;
    logic [9:0] held;
    int k;
    write_run(1'b0);
    @(posedge ref_clk_i);
    act <= ACT_PULSE;
    init_lvl <= 1'b1;
    p_val <= 10'h003;
    write_a(10'h032);
    clear_flags;
    write_run(1'b1);
    measure(200, hi, top);
    check(hi, 16'h0032);
    check({14'h0000, run_o, a_flag}, 16'h0001);
    held = cnt;
    @(posedge ref_clk_i);
    p_val <= 10'h001;
    swap <= 1'b1;
    cyc(10);
    check({6'h00, cnt}, {6'h00, held});
    write_run(1'b1);
    cyc(1);
    check({6'h00, cnt}, 16'h0000);
    check({15'h0000, tout}, 16'h0001);
    cyc(8);
    write_run(1'b0);
    cyc(2);
    check({14'h0000, run_o, tout}, 16'h0000);
    pins.trigger();
    k = 0;
    while (run_o !== 1'b1 && k < 20) begin
      @(posedge ref_clk_i);
      k++;
    end
    cyc(2);
    check({14'h0000, run_o, tout}, 16'h0003);
  endtask

  task automatic test_capture;
    logic [9:0] c0;
    logic [15:0] hi, top;
    logic got;
    int k;
    write_run(1'b0);
    @(posedge ref_clk_i);
    mode <= MODE_CAPTURE;
    p_val <= 10'h000;
    div <= 4;
    write_run(1'b1);
    for (int e = 0; e < 4; e++) begin
      @(posedge ref_clk_i);
      act <= e[1:0];
      for (int lv = 1; lv >= 0; lv--) begin
        clear_flags;
        cyc(4);
        c0 = cnt;
        pins.set_cap(lv[0]);
        k = 0;
        while (a_flag !== 1'b1 && k < 12) begin
          @(posedge ref_clk_i);
          k++;
        end
        got = a_flag;
        if (got === 1'b1) check({15'h0000, irq}, 16'h0001);
        if (got === 1'b1) check({15'h0000, (a_val - c0) <= 10'h002}, 16'h0001);
        check({15'h0000, got}, (lv == 1) ? {15'h0000, e == 0 || e == 2} :
          {15'h0000, e == 1 || e == 2});
      end
    end
    c0 = cnt;
    cyc(8);
    check({15'h0000, cnt != c0}, 16'h0001);
    @(posedge ref_clk_i);
    div <= 1;
    p_val <= 10'h014;
    write_run(1'b0);
    clear_flags;
    write_run(1'b1);
    measure(42, hi, top);
    check(top, 16'h0014);
    check(hi, 16'h0000);
    check({15'h0000, p_flag}, 16'h0001);
    write_run(1'b0);
    c0 = cnt;
    cyc(5);
    check({6'h00, cnt}, {6'h00, c0});
  endtask

  // ------------------------------------------------------------
  // closing and run control
  // ------------------------------------------------------------
  task automatic end_sim;
    $display("compared=%0d errors=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_total++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    cyc(2);
    test_reset();
    test_pwm();
    test_pulse();
    test_capture();
    end_sim();
  end
endmodule
